// >>> hw/ast_pkg.sv
package ast_pkg;

	// ****************************************************************
	// Register port geometry
	// ****************************************************************
	localparam int ADDR_W = 4;                 // Register address width
	localparam int DATA_W = 16;                // Register data width
	localparam int CTRL_W = 11;                // Control register width
	localparam int TMR_W  = 24;                // Bit timer width
	localparam int CHAR_W = 9;                 // Widest character

	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0; // Control, read/write
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4; // Status, read only
	localparam logic [ADDR_W-1:0] REG_BAUD   = 4'h8; // Baud divisor
	localparam logic [ADDR_W-1:0] REG_TXBUF  = 4'hc; // Transmit buffer

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int C_SERIAL_PORT_ENABLE  = 0;   // serial_port_enable
	localparam int C_SYNC  = 1;   // Mode select, 0 = asynchronous
	localparam int C_TX_ENABLE_BIT  = 2;   // tx_enable_bit
	localparam int C_NINE  = 3;   // nine_bit_tx_enable
	localparam int C_POL   = 4;   // tx_polarity_select
	localparam int C_NINTH = 5;   // tx_ninth_bit
	localparam int C_BAUD_HIGH_SPEED  = 6;   // baud_high_speed
	localparam int C_BAUD_16BIT_SELECT = 7;   // baud_16bit_select
	localparam int C_TXIE  = 8;   // tx_irq_enable
	localparam int C_PERIPHERAL_IRQ_MASTER_ENABLE  = 9;   // peripheral_irq_master_enable
	localparam int C_GIE   = 10;  // global_irq_enable

	// Status register fields
	localparam int S_FLAG  = 0;   // tx_irq_flag
	localparam int S_EMPTY = 1;   // shift_empty_status

	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000; // Control reset
	localparam logic [DATA_W-1:0] BAUD_RST = 16'h0000; // Divisor reset

	// ****************************************************************
	// Baud prescale per speed selection
	// ****************************************************************
	localparam logic [6:0] PRE_SLOW = 7'h40;  // Both speed bits clear
	localparam logic [6:0] PRE_MID  = 7'h10;  // One speed bit set
	localparam logic [6:0] PRE_FAST = 7'h04;  // Both speed bits set

	localparam logic [3:0] LAST_BIT_8 = 4'h7; // Last index, 8 data bits
	localparam logic [3:0] LAST_BIT_9 = 4'h8; // Last index, 9 data bits

	// Frame position shared by both ends
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} ast_frame_type;

endpackage

// >>> hw/ast_line_if.sv
`timescale 1ns/1ps
// Serial line between transmitter and remote receiver
interface ast_line_if;
	logic ser_data;      // Line level driven by the transmitter
	logic ser_drive_en;  // High while the transmitter drives the line

	// Transmitter end
	modport dev_mp (
		output ser_data,
		output ser_drive_en
	);

	// Remote receiver end
	modport rcv_mp (
		input ser_data,
		input ser_drive_en
	);
endinterface

// >>> hw/ast_tx.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ast_tx (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic [ast_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [ast_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [ast_pkg::DATA_W-1:0] rdata_o,
	output logic                           irq_o,
	ast_line_if.dev_mp                     line
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		ast_pkg::ast_frame_type           st;      // Frame position
		logic [ast_pkg::TMR_W-1:0]        tmr;     // Clocks into bit
		logic [3:0]                       nbits;   // Data bit index
		logic [ast_pkg::CHAR_W-1:0]       shf;     // tx_shift_reg
		logic [ast_pkg::CHAR_W-1:0]       hold;    // tx_buffer
		logic                             full;    // Buffer pending
		logic [ast_pkg::CTRL_W-1:0]       ctrl;    // Control bits
		logic [ast_pkg::DATA_W-1:0]       div;     // Baud divisor
		logic                             flag;    // tx_irq_flag
		logic                             irq;     // Interrupt request
		logic                             line;    // Line level
		logic                             drv;     // Line driver on
		logic [ast_pkg::DATA_W-1:0]       rdata;   // Read answer
	} ast_tx_state_type;

	ast_tx_state_type s_q;         // Registered state
	ast_tx_state_type s_d;         // Next state
	logic [6:0]                  pre;     // Selected prescale
	logic [ast_pkg::DATA_W-1:0]  div_eff; // Divisor in use
	logic [ast_pkg::TMR_W-1:0]   per_m1;  // Clocks per bit minus one
	logic                        en;      // Transmitter may run
	logic                        bit_end; // Last clock of a bit
	logic [3:0]                  last;    // Index of final data bit

	// ****************************************************************
	// Baud period
	// ****************************************************************
	// Prescale from the two speed bits, divisor 8 or 16 bit wide
	always_comb begin
		unique case ({s_q.ctrl[ast_pkg::C_BAUD_16BIT_SELECT], s_q.ctrl[ast_pkg::C_BAUD_HIGH_SPEED]})
			2'b00: pre = ast_pkg::PRE_SLOW;
			2'b11: pre = ast_pkg::PRE_FAST;
			default: pre = ast_pkg::PRE_MID;
		endcase
		div_eff = s_q.ctrl[ast_pkg::C_BAUD_16BIT_SELECT] ? s_q.div
			: {8'h00, s_q.div[7:0]};
		per_m1 = ast_pkg::TMR_W'(pre) *
			(ast_pkg::TMR_W'(div_eff) + 24'h000001) - 24'h000001;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Register writes, then the frame sequencer, then outputs
	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		en = s_q.ctrl[ast_pkg::C_SERIAL_PORT_ENABLE] & s_q.ctrl[ast_pkg::C_TX_ENABLE_BIT]
			& ~s_q.ctrl[ast_pkg::C_SYNC];
		bit_end = (s_q.tmr == per_m1);
		last = s_q.ctrl[ast_pkg::C_NINE] ? ast_pkg::LAST_BIT_9
			: ast_pkg::LAST_BIT_8;

		// Writes; status holds no writable bit
		if (wr_i) begin
			unique case (addr_i)
				ast_pkg::REG_CTRL: begin
					s_d.ctrl = wdata_i[ast_pkg::CTRL_W-1:0];
				end
				ast_pkg::REG_BAUD: begin
					s_d.div = wdata_i;
				end
				ast_pkg::REG_TXBUF: begin
					// Ninth bit already sits in control
					if (en) begin
						s_d.hold = {s_q.ctrl[ast_pkg::C_NINTH]
							& s_q.ctrl[ast_pkg::C_NINE],
							wdata_i[7:0]};
						s_d.full = 1'b1;
					end
				end
				default: begin
					// Status and unmapped: writes ignored
				end
			endcase
		end

		// Reads answer in the next cycle
		if (rd_i) begin
			unique case (addr_i)
				ast_pkg::REG_CTRL: s_d.rdata = {5'h00, s_q.ctrl};
				ast_pkg::REG_BAUD: s_d.rdata = s_q.div;
				ast_pkg::REG_STATUS: begin
					s_d.rdata[ast_pkg::S_FLAG]  = s_q.flag;
					s_d.rdata[ast_pkg::S_EMPTY] =
						(s_q.st == ast_pkg::ST_IDLE);
				end
				default: s_d.rdata = '0;
			endcase
		end

		// Frame sequencer
		unique case (s_q.st)
			ast_pkg::ST_IDLE: begin
				// Empty shifter takes the character at once
				if (s_d.full) begin
					s_d.shf  = s_d.hold;
					s_d.full = 1'b0;
					s_d.tmr  = '0;
					s_d.st   = ast_pkg::ST_START;
				end
			end
			ast_pkg::ST_START: begin
				s_d.tmr = s_q.tmr + 24'h000001;
				if (bit_end) begin
					s_d.tmr   = '0;
					s_d.nbits = 4'h0;
					s_d.st    = ast_pkg::ST_DATA;
				end
			end
			ast_pkg::ST_DATA: begin
				s_d.tmr = s_q.tmr + 24'h000001;
				if (bit_end) begin
					s_d.tmr   = '0;
					s_d.shf   = {1'b0, s_q.shf[8:1]};
					s_d.nbits = s_q.nbits + 4'h1;
					if (s_q.nbits == last) begin
						s_d.st = ast_pkg::ST_STOP;
					end
				end
			end
			ast_pkg::ST_STOP: begin
				s_d.tmr = s_q.tmr + 24'h000001;
				if (bit_end) begin
					s_d.tmr = '0;
					// Queued character starts without a gap
					if (s_d.full) begin
						s_d.shf  = s_d.hold;
						s_d.full = 1'b0;
						s_d.st   = ast_pkg::ST_START;
					end else begin
						s_d.st = ast_pkg::ST_IDLE;
					end
				end
			end
		endcase

		// Disabled transmitter drops the frame in progress and the pending character
		if (!en) begin
			s_d.st    = ast_pkg::ST_IDLE;
			s_d.tmr   = '0;
			s_d.nbits = 4'h0;
			s_d.shf   = '0;
			s_d.full  = 1'b0;
		end

		// Line level from the next frame position
		unique case (s_d.st)
			ast_pkg::ST_START: s_d.line = 1'b0;
			ast_pkg::ST_DATA:  s_d.line = s_d.shf[0];
			default:           s_d.line = 1'b1;
		endcase
		s_d.line = s_d.line ^ s_q.ctrl[ast_pkg::C_POL];
		s_d.drv  = s_q.ctrl[ast_pkg::C_SERIAL_PORT_ENABLE];

		// Flag follows buffer state, one cycle behind
		s_d.flag = s_q.ctrl[ast_pkg::C_TX_ENABLE_BIT] & ~s_q.full;
		s_d.irq  = s_q.flag & s_q.ctrl[ast_pkg::C_TXIE]
			& s_q.ctrl[ast_pkg::C_PERIPHERAL_IRQ_MASTER_ENABLE] & s_q.ctrl[ast_pkg::C_GIE];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q      <= '0;
			s_q.ctrl <= ast_pkg::CTRL_RST;
			s_q.div  <= ast_pkg::BAUD_RST;
			s_q.line <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign rdata_o           = s_q.rdata;
	assign irq_o             = s_q.irq;
	assign line.ser_data     = s_q.line;
	assign line.ser_drive_en = s_q.drv;

endmodule

// >>> hw/ast_rx.sv
`timescale 1ns/1ps
// Remote receiver: samples mid-bit, reports each character
module ast_rx (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       nine_bit_i,
	input  wire logic                       polarity_i,
	input  wire logic [ast_pkg::TMR_W-1:0]  bit_period_m1_i,
	output logic      [ast_pkg::CHAR_W-1:0] data_o,
	output logic                            valid_o,
	output logic                            frame_err_o,
	ast_line_if.rcv_mp                      line
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		ast_pkg::ast_frame_type      st;     // Frame position
		logic [ast_pkg::TMR_W-1:0]   tmr;    // Clocks into bit
		logic [3:0]                  nbits;  // Data bit index
		logic [ast_pkg::CHAR_W-1:0]  shf;    // Incoming bits
		logic [ast_pkg::CHAR_W-1:0]  data;   // Last character
		logic                        valid;  // Character pulse
		logic                        ferr;   // Stop bit was space
	} ast_rx_state_type;

	ast_rx_state_type s_q;   // Registered state
	ast_rx_state_type s_d;   // Next state
	logic             lvl;   // True line level, undriven reads mark
	logic [3:0]       last;  // Index of final data bit

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.valid = 1'b0;
		lvl = line.ser_drive_en ? (line.ser_data ^ polarity_i) : 1'b1;
		last = nine_bit_i ? ast_pkg::LAST_BIT_9 : ast_pkg::LAST_BIT_8;
		s_d.tmr = s_q.tmr + 24'h000001;
		unique case (s_q.st)
			ast_pkg::ST_IDLE: begin
				// Wait for a start edge
				s_d.tmr = '0;
				if (!lvl) begin
					s_d.st = ast_pkg::ST_START;
				end
			end
			ast_pkg::ST_START: begin
				// Confirm start at its middle
				if (s_q.tmr == (bit_period_m1_i >> 1)) begin
					s_d.tmr   = '0;
					s_d.nbits = 4'h0;
					s_d.st    = lvl ? ast_pkg::ST_IDLE : ast_pkg::ST_DATA;
				end
			end
			ast_pkg::ST_DATA: begin
				// Sample each data bit at its middle
				if (s_q.tmr == bit_period_m1_i) begin
					s_d.tmr   = '0;
					s_d.shf   = {lvl, s_q.shf[8:1]};
					s_d.nbits = s_q.nbits + 4'h1;
					if (s_q.nbits == last) begin
						s_d.st = ast_pkg::ST_STOP;
					end
				end
			end
			ast_pkg::ST_STOP: begin
				// Stop bit sample closes the character
				if (s_q.tmr == bit_period_m1_i) begin
					s_d.tmr   = '0;
					s_d.data  = nine_bit_i ? s_q.shf : {1'b0, s_q.shf[8:1]};
					s_d.ferr  = ~lvl;
					s_d.valid = 1'b1;
					s_d.st    = ast_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign data_o      = s_q.data;
	assign valid_o     = s_q.valid;
	assign frame_err_o = s_q.ferr;

endmodule

// >>> tb/ast_monitor.sv
`timescale 1ns/1ps
// ****************************************************************
// Line checker, bit length taken from the receiver's period
// ****************************************************************
module ast_monitor (
	input wire logic                      sys_clk_i,
	input wire logic                      rst_i,
	input wire logic                      nine_bit_i,
	input wire logic                      polarity_i,
	input wire logic                      ser_data,
	input wire logic                      ser_drive_en,
	input wire logic [ast_pkg::TMR_W-1:0] bit_period_m1_i
);
	logic                      in_frame_q; // Inside a frame
	logic [ast_pkg::TMR_W-1:0] cnt_q;      // Clock within the bit
	logic [3:0]                idx_q;      // Bit index, start is 0
	logic                      prev_d_q;   // Line one cycle ago
	logic                      prev_e_q;   // Drive enable one cycle ago
	logic [3:0]                last;       // Index of the stop bit
	assign last = nine_bit_i ? 4'ha : 4'h9;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Follows frames from the edge into the start bit
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_frame_q <= 1'b0;
			cnt_q      <= '0;
			idx_q      <= 4'h0;
			prev_d_q   <= 1'b1;
			prev_e_q   <= 1'b0;
		end else begin
			prev_d_q <= ser_data;
			prev_e_q <= ser_drive_en;
			if (!ser_drive_en) begin
				in_frame_q <= 1'b0;
			end else if (!in_frame_q) begin
				if (prev_e_q && prev_d_q != polarity_i && ser_data == polarity_i) begin
					in_frame_q <= 1'b1;
					cnt_q      <= 24'h000001;
					idx_q      <= 4'h0;
				end
			end else if (cnt_q != bit_period_m1_i) begin
				// Still inside the bit
				cnt_q <= cnt_q + 24'h000001;
			end else begin
				// Bit boundary: next bit or frame done
				cnt_q <= '0;
				if (idx_q == last) begin
					in_frame_q <= 1'b0;
				end else begin
					idx_q <= idx_q + 4'h1;
				end
			end
		end
	end
	chk_bit_hold: assert property (
		in_frame_q && ser_drive_en && cnt_q != '0 |-> $stable(ser_data))
		else $error("Line changed inside a bit");
	chk_start_len: assert property (
		!in_frame_q && ser_drive_en && prev_e_q && prev_d_q != polarity_i
		&& ser_data == polarity_i |=> (ser_data == polarity_i) [*3])
		else $error("Start bit too short");
	chk_stop_mark: assert property (
		in_frame_q && ser_drive_en && idx_q == last |-> ser_data != polarity_i)
		else $error("Stop bit not at mark");
	chk_stop_len: assert property (
		in_frame_q && idx_q == last && cnt_q == '0
		|-> (ser_data != polarity_i) [*4])
		else $error("Stop bit too short");
	chk_off_idle: assert property (
		!ser_drive_en && !polarity_i |-> ser_data)
		else $error("Line not idle while disabled");
	chk_reset_line: assert property (
		$fell(rst_i) |-> ser_data && !ser_drive_en)
		else $error("Line wrong after reset");
	chk_idle_level: assert property (
		!in_frame_q && ser_drive_en && $past(ser_drive_en, 3)
		&& ser_data == polarity_i |=> in_frame_q)
		else $error("Idle line at space level");
	chk_idle_exit: assert property (
		!in_frame_q && $changed(ser_data) && $past(ser_drive_en, 3)
		&& ser_drive_en && $stable(polarity_i) |-> ser_data == polarity_i)
		else $error("Idle line left without a start");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic        sys_clk_i = 1'b0;  // System clock
	logic        rst_i     = 1'b1;  // Reset, active high
	logic [3:0]  addr_i    = 4'h0;  // Register address
	logic [15:0] wdata_i   = 16'h0; // Write data
	logic        wr_i      = 1'b0;  // Write strobe
	logic        rd_i      = 1'b0;  // Read strobe
	logic        nine_bit  = 1'b0;  // Receiver nine-bit mode
	logic        polarity  = 1'b0;  // Receiver inversion
	logic [23:0] rx_per    = 24'h000003; // Receiver clocks a bit, less one
	logic [15:0] rdata_o;           // Read data
	logic        irq_o;             // Interrupt request
	logic [8:0]  data_o;            // Received character
	logic        valid_o;           // Character pulse
	logic        frame_err_o;       // Stop bit error
	logic [15:0] rv;                // Last read value
	int          n;                 // Cycles to a character
	int          err_count = 0;
	int          cmp_count = 0;
	int          cycles    = 0;
	localparam logic [15:0] EN = 16'((1 << ast_pkg::C_SERIAL_PORT_ENABLE) |
		(1 << ast_pkg::C_TX_ENABLE_BIT) | (1 << ast_pkg::C_BAUD_HIGH_SPEED) |
		(1 << ast_pkg::C_BAUD_16BIT_SELECT));
	localparam logic [15:0] IRQS = 16'((1 << ast_pkg::C_TXIE) |
		(1 << ast_pkg::C_PERIPHERAL_IRQ_MASTER_ENABLE) | (1 << ast_pkg::C_GIE));
	localparam logic [15:0] F = 16'(1 << ast_pkg::S_FLAG);
	localparam logic [15:0] E = 16'(1 << ast_pkg::S_EMPTY);
	ast_line_if line_if ();
	ast_tx ast_tx_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_o(irq_o), .line(line_if));
	// Receiver period is set to match the transmitter's
	ast_rx ast_rx_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.nine_bit_i(nine_bit), .polarity_i(polarity),
		.bit_period_m1_i(rx_per), .data_o(data_o), .valid_o(valid_o),
		.frame_err_o(frame_err_o), .line(line_if));
	ast_monitor ast_monitor_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.nine_bit_i(nine_bit), .polarity_i(polarity),
		.ser_data(line_if.ser_data), .ser_drive_en(line_if.ser_drive_en),
		.bit_period_m1_i(rx_per));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Cuts a hang short
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	// ****************************************************************
	// Bus cycles and comparisons
	// ****************************************************************
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask
	// Waits for a character and judges it with its flags
	task automatic rx_get(input logic [8:0] exp);
		n = 0;
		do begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end while (valid_o !== 1'b1 && n < 300);
		check({5'h0, frame_err_o, valid_o, data_o}, {7'h01, exp});
	endtask
	task automatic line_is(input logic lvl);
		check({15'h0, line_if.ser_data}, {15'h0, lvl});
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_flag();
		rd_chk(ast_pkg::REG_CTRL, 16'h0000);
		rd_chk(ast_pkg::REG_STATUS, E);
		rd_chk(4'h2, 16'h0000);
		wr_reg(ast_pkg::REG_CTRL, EN);
		rd_chk(ast_pkg::REG_STATUS, F | E);
		wr_reg(ast_pkg::REG_STATUS, 16'h0000);
		rd_chk(ast_pkg::REG_STATUS, F | E);
		wr_reg(ast_pkg::REG_CTRL, EN | IRQS);
		repeat (2) @(posedge sys_clk_i);
		#1;
		check({15'h0, irq_o}, 16'h0001);
		wr_reg(ast_pkg::REG_CTRL, EN | (IRQS & ~16'(1 << ast_pkg::C_TXIE)));
		repeat (2) @(posedge sys_clk_i);
		#1;
		check({15'h0, irq_o}, 16'h0000);
		rd_chk(ast_pkg::REG_STATUS, F | E);
	endtask
	task automatic t_frames();
		wr_reg(ast_pkg::REG_TXBUF, 16'h00a5);
		rd_chk(ast_pkg::REG_STATUS, F);
		rx_get(9'h0a5);
		repeat (6) @(posedge sys_clk_i);
		rd_chk(ast_pkg::REG_STATUS, F | E);
		wr_reg(ast_pkg::REG_TXBUF, 16'h003c);
		wr_reg(ast_pkg::REG_TXBUF, 16'h00c3);
		rd_chk(ast_pkg::REG_STATUS, 16'h0000);
		rx_get(9'h03c);
		rx_get(9'h0c3);
		check(16'(n), 16'h0028);
		repeat (6) @(posedge sys_clk_i);
		rd_chk(ast_pkg::REG_STATUS, F | E);
	endtask
	task automatic t_nine();
		@(posedge sys_clk_i);
		nine_bit <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr_reg(ast_pkg::REG_CTRL, EN | 16'(1 << ast_pkg::C_NINE) |
				((i == 0) ? 16'(1 << ast_pkg::C_NINTH) : 16'h0000));
			wr_reg(ast_pkg::REG_TXBUF, (i == 0) ? 16'h0055 : 16'h00fe);
			rx_get((i == 0) ? 9'h155 : 9'h0fe);
		end
		repeat (6) @(posedge sys_clk_i);
		nine_bit <= 1'b0;
	endtask
	task automatic t_pol();
		wr_reg(ast_pkg::REG_CTRL, 16'h0000);
		// Receiver flips only once the line is undriven
		@(posedge sys_clk_i);
		polarity <= 1'b1;
		wr_reg(ast_pkg::REG_CTRL, 16'(1 << ast_pkg::C_POL));
		wr_reg(ast_pkg::REG_CTRL, EN | 16'(1 << ast_pkg::C_POL));
		repeat (4) @(posedge sys_clk_i);
		#1;
		line_is(1'b0);
		wr_reg(ast_pkg::REG_TXBUF, 16'h0096);
		rx_get(9'h096);
		repeat (6) @(posedge sys_clk_i);
		wr_reg(ast_pkg::REG_CTRL, 16'h0000);
		repeat (3) @(posedge sys_clk_i);
		polarity <= 1'b0;
	endtask
	task automatic t_abort();
		wr_reg(ast_pkg::REG_CTRL, EN);
		wr_reg(ast_pkg::REG_TXBUF, 16'h0000);
		repeat (10) @(posedge sys_clk_i);
		wr_reg(ast_pkg::REG_CTRL, 16'h0000);
		repeat (2) @(posedge sys_clk_i);
		#1;
		line_is(1'b1);
		rd_chk(ast_pkg::REG_STATUS, E);
		repeat (60) @(posedge sys_clk_i);
		wr_reg(ast_pkg::REG_CTRL, EN | 16'(1 << ast_pkg::C_SYNC));
		wr_reg(ast_pkg::REG_TXBUF, 16'h005a);
		repeat (8) @(posedge sys_clk_i);
		#1;
		line_is(1'b1);
		rd_chk(ast_pkg::REG_STATUS, F | E);
	endtask
	// Both divider widths and two prescales
	task automatic t_baud();
		// Eight-bit divider ignores the high byte: sixteen clocks a bit
		wr_reg(ast_pkg::REG_BAUD, 16'h0100);
		rx_per <= 24'(ast_pkg::PRE_MID) - 24'h000001;
		rd_chk(ast_pkg::REG_BAUD, 16'h0100);
		wr_reg(ast_pkg::REG_CTRL, 16'((1 << ast_pkg::C_SERIAL_PORT_ENABLE) |
			(1 << ast_pkg::C_TX_ENABLE_BIT) | (1 << ast_pkg::C_BAUD_HIGH_SPEED)));
		wr_reg(ast_pkg::REG_TXBUF, 16'h0069);
		rx_get(9'h069);
		repeat (10) @(posedge sys_clk_i);
		// Sixteen-bit divider of one, fast prescale: eight clocks a bit
		wr_reg(ast_pkg::REG_BAUD, 16'h0001);
		rx_per <= 24'(ast_pkg::PRE_FAST) * 24'h000002 - 24'h000001;
		wr_reg(ast_pkg::REG_CTRL, EN);
		wr_reg(ast_pkg::REG_TXBUF, 16'h009c);
		rx_get(9'h09c);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_flag();
		t_frames();
		t_nine();
		t_pol();
		t_abort();
		t_baud();
		wrap_up();
	end
endmodule
